// *** design/tcmf_pkg.sv ***
/*
  tcmf_pkg: constants shared by the conflict monitor fault logic.
  assumes a 40 MHz system clock and a 1 ms timebase tick built from it.
*/
package tcmf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NCH = 18;
  localparam int MS_W = 11;
  localparam int NEV = 6;

  ////////////////////////////////////////////////////////////////////////////
  // timebase
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // fault timings in ms
  localparam logic [MS_W-1:0] RF_ON_MS = 11'h546;
  localparam logic [MS_W-1:0] RF_OFF_MS = 11'h352;
  localparam logic [MS_W-1:0] WD_ON_MS = 11'h3E8;
  localparam logic [MS_W-1:0] WD_OFF_MS = 11'h5DC;
  localparam logic [MS_W-1:0] BO_ON_MS = 11'h190;
  localparam logic [MS_W-1:0] BO_OFF_MS = 11'h064;
  localparam logic [MS_W-1:0] INH_MS = 11'h226;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RF_EN = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_CH_CAPT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int CTRL_RESET_BIT = 0;
  localparam int F_CONFLICT = 0;
  localparam int F_REDFAIL = 1;
  localparam int F_WDT = 2;
  localparam int F_CARD = 3;
  localparam int F_CABLE = 4;
  localparam int F_BROWN = 5;
  localparam int FS_INH1 = 6;
  localparam int FS_INH2 = 7;
  localparam int FS_MODE = 8;
  localparam logic [NCH-1:0] RF_EN_RST = 18'h3_FFFF;
  localparam logic [NEV-1:0] IRQ_MASK_RST = 6'h00;

endpackage : tcmf_pkg

// *** design/tcmf_persist.sv ***
/*
  tcmf_persist: reports a level only after it has stood for a number of
  1 ms ticks. assumes level_i and tick_i are on clk_i already.
*/
`timescale 1ns/1ps
`default_nettype none
module tcmf_persist #(
  parameter int W = 11
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // timing
  input wire logic tick_i,
  input wire logic [W-1:0] limit_i,
  // level in, qualified level out
  input wire logic level_i,
  output logic held_o
);

  logic [W-1:0] cnt_r;

  // any drop restarts the count, so only a continuous level qualifies
  always_ff @(posedge clk_i) begin
    if (rst_i || !level_i) begin
      cnt_r <= '0;
    end else if (tick_i && cnt_r < limit_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign held_o = level_i && (cnt_r >= limit_i);

endmodule : tcmf_persist
`default_nettype wire

// *** design/tcmf_monitor.sv ***
/*
  tcmf_monitor: fault supervision of an 18 channel signal conflict monitor,
  with an APB register slave and one level interrupt.
  assumes field, option and cable inputs arrive as qualified digital levels
  from another domain; conflict detection is done outside and reported.
*/
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcmf_monitor
  import tcmf_pkg::*;
#(
  parameter int TICK_CYC = tcmf_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  // field signals per channel
  input wire logic [tcmf_pkg::NCH-1:0] red_i,
  input wire logic [tcmf_pkg::NCH-1:0] yel_i,
  input wire logic [tcmf_pkg::NCH-1:0] grn_i,
  // cabinet inputs
  input wire logic red_enable_i,
  input wire logic red_inhibit1_i,
  input wire logic red_inhibit2_i,
  input wire logic output_relay_common_sense_i,
  input wire logic program_card_present_i,
  input wire logic red_interface_cable_i,
  input wire logic watchdog_i,
  input wire logic low_line_i,
  input wire logic dc_fail_i,
  input wire logic conflict_i,
  input wire logic front_reset_i,
  input wire logic remote_reset_i,
  // option switches and jumpers
  input wire logic orc_polarity_jmp_i,
  input wire logic rf_time_sel_i,
  input wire logic wd_time_sel_i,
  input wire logic brownout_sel_i,
  input wire logic wd_latch_sel_i,
  // indicators and cabinet command
  output logic power_led_o,
  output logic dc_supply_fail_indicator_o,
  output logic watchdog_timeout_fault_o,
  output logic conflict_led_o,
  output logic red_fail_led_o,
  output logic dual_ind_led_o,
  output logic clearance_led_o,
  output logic program_card_absent_indicator_o,
  output logic diag_fail_led_o,
  output logic flash_cmd_o,
  output logic [tcmf_pkg::NCH-1:0] ch_red_o,
  output logic [tcmf_pkg::NCH-1:0] ch_yel_o,
  output logic [tcmf_pkg::NCH-1:0] ch_grn_o
);

  localparam int NS = 3 * NCH + 17;
  localparam int TW = 16;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and 1 ms tick
  logic [NS-1:0] sync1_r, sync2_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick;
  logic [NCH-1:0] red_s, yel_s, grn_s;
  logic ren_s, inh1_s, inh2_s, orc_s, card_s, cable_s, wd_s, low_s;
  logic dcf_s, conf_s, frst_s, rrst_s, pol_s, rfsel_s, wdsel_s, bosel_s, wdl_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {red_i, yel_i, grn_i, red_enable_i, red_inhibit1_i, red_inhibit2_i,
                  output_relay_common_sense_i, program_card_present_i,
                  red_interface_cable_i, watchdog_i, low_line_i, dc_fail_i, conflict_i,
                  front_reset_i, remote_reset_i, orc_polarity_jmp_i, rf_time_sel_i,
                  wd_time_sel_i, brownout_sel_i, wd_latch_sel_i};
      sync2_r <= sync1_r;
    end
  end

  assign {red_s, yel_s, grn_s, ren_s, inh1_s, inh2_s, orc_s, card_s, cable_s, wd_s,
          low_s, dcf_s, conf_s, frst_s, rrst_s, pol_s, rfsel_s, wdsel_s, bosel_s,
          wdl_s} = sync2_r;

  // one tick every millisecond of clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // qualified conditions
  logic inh1_act, inh2_act, orc_act, mon_en, bo_act, wd_to;
  logic wd_prev_r, bo_prev_r;
  logic [NCH-1:0] rf_hit, rf_en_r;
  logic [MS_W-1:0] rf_lim, wd_lim, bo_lim;

  assign rf_lim = rfsel_s ? RF_ON_MS : RF_OFF_MS;
  assign wd_lim = wdsel_s ? WD_ON_MS : WD_OFF_MS;
  assign bo_lim = bosel_s ? BO_ON_MS : BO_OFF_MS;

  // short inhibit pulses never reach the threshold
  tcmf_persist #(.W(MS_W)) u_inh1 (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .limit_i(INH_MS), .level_i(inh1_s), .held_o(inh1_act));
  tcmf_persist #(.W(MS_W)) u_inh2 (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .limit_i(INH_MS), .level_i(inh2_s), .held_o(inh2_act));
  tcmf_persist #(.W(MS_W)) u_bo (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .limit_i(bo_lim), .level_i(low_s), .held_o(bo_act));
  // watchdog timer restarts on every toggle and idles in brown-out
  tcmf_persist #(.W(MS_W)) u_wd (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .limit_i(wd_lim), .level_i((wd_s == wd_prev_r) && !bo_act),
    .held_o(wd_to));

  assign orc_act = orc_s ^ pol_s;
  assign mon_en = ren_s && !inh1_act && !inh2_act && !orc_act;

  // absence of any indication on a channel, per channel enable
  for (genvar c = 0; c < NCH; c++) begin : g_rf
    tcmf_persist #(.W(MS_W)) u_rf (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
      .limit_i(rf_lim),
      .level_i(mon_en && rf_en_r[c] && !(red_s[c] || yel_s[c] || grn_s[c])),
      .held_o(rf_hit[c]));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_prev_r <= 1'b0;
      bo_prev_r <= 1'b0;
    end else begin
      wd_prev_r <= wd_s;
      bo_prev_r <= bo_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched faults
  logic [4:0] flag_r, fset;
  logic fault_r, rst_cmd, sw_rst_r, bo_rise;
  logic [NCH-1:0] ch_capt_r;

  assign rst_cmd = frst_s || rrst_s || sw_rst_r;
  assign bo_rise = bo_act && !bo_prev_r;
  assign fset[F_CONFLICT] = conf_s;
  assign fset[F_REDFAIL] = |rf_hit;
  assign fset[F_WDT] = wd_to;
  assign fset[F_CARD] = !card_s;
  assign fset[F_CABLE] = !cable_s;

  // a new fault wins over a reset in the same cycle, so a card or cable still
  // missing keeps its fault through any reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= '0;
    end else begin
      flag_r[F_CONFLICT] <= fset[F_CONFLICT] || (flag_r[F_CONFLICT] && !rst_cmd);
      flag_r[F_REDFAIL] <= fset[F_REDFAIL] || (flag_r[F_REDFAIL] && !rst_cmd);
      flag_r[F_CARD] <= fset[F_CARD] || (flag_r[F_CARD] && !rst_cmd);
      flag_r[F_CABLE] <= fset[F_CABLE] || (flag_r[F_CABLE] && !rst_cmd);
      flag_r[F_WDT] <= fset[F_WDT] ||
                       (flag_r[F_WDT] && !rst_cmd && (wdl_s || !bo_rise));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= |fset || (fault_r && (|flag_r) && !rst_cmd);
    end
  end

  // conflict keeps the channels that were on, red fail the failed ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_capt_r <= '0;
    end else if (rst_cmd && !(|fset)) begin
      ch_capt_r <= '0;
    end else if (!fault_r && fset[F_CONFLICT]) begin
      ch_capt_r <= red_s | yel_s | grn_s;
    end else begin
      ch_capt_r <= ch_capt_r | rf_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators; channel status freezes while in fault mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_red_o <= '0;
      ch_yel_o <= '0;
      ch_grn_o <= '0;
    end else if (!fault_r) begin
      ch_red_o <= red_s;
      ch_yel_o <= yel_s;
      ch_grn_o <= grn_s;
    end
  end

  // dual, clearance and self-test checks live elsewhere; dual and clearance lamps held dark, diag lamp shows the cable fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_led_o <= 1'b0;
      dc_supply_fail_indicator_o <= 1'b0;
      watchdog_timeout_fault_o <= 1'b0;
      conflict_led_o <= 1'b0;
      red_fail_led_o <= 1'b0;
      dual_ind_led_o <= 1'b0;
      clearance_led_o <= 1'b0;
      program_card_absent_indicator_o <= 1'b0;
      diag_fail_led_o <= 1'b0;
      flash_cmd_o <= 1'b0;
    end else begin
      power_led_o <= !bo_act;
      dc_supply_fail_indicator_o <= dcf_s;
      watchdog_timeout_fault_o <= flag_r[F_WDT];
      conflict_led_o <= flag_r[F_CONFLICT];
      red_fail_led_o <= flag_r[F_REDFAIL];
      program_card_absent_indicator_o <= flag_r[F_CARD];
      diag_fail_led_o <= flag_r[F_CABLE];
      flash_cmd_o <= fault_r || bo_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer on the second access cycle
  logic acc, wr;
  logic [NEV-1:0] irq_stat_r, irq_mask_r, ev;
  logic [31:0] rd_nxt;
  logic bad_nxt;

  assign acc = psel_i && penable_i && pready_o;
  assign wr = acc && pwrite_i;

  always_comb begin
    rd_nxt = '0;
    bad_nxt = 1'b0;
    unique case (paddr_i)
      ADDR_CTRL: rd_nxt = '0;
      ADDR_RF_EN: rd_nxt[NCH-1:0] = rf_en_r;
      ADDR_FAULT: rd_nxt[FS_MODE:0] = {fault_r, inh2_act, inh1_act, bo_act, flag_r};
      ADDR_CH_CAPT: rd_nxt[NCH-1:0] = ch_capt_r;
      ADDR_IRQ_STAT: rd_nxt[NEV-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_nxt[NEV-1:0] = irq_mask_r;
      default: bad_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      prdata_o <= (psel_i && !pwrite_i && !pready_o) ? rd_nxt : '0;
      pslverr_o <= psel_i && penable_i && !pready_o && bad_nxt;
    end
  end

  // software reset command is a one-cycle pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_rst_r <= 1'b0;
      rf_en_r <= RF_EN_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      sw_rst_r <= wr && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_RESET_BIT];
      if (wr && paddr_i == ADDR_RF_EN) begin
        rf_en_r <= pwdata_i[NCH-1:0];
      end
      if (wr && paddr_i == ADDR_IRQ_MASK) begin
        irq_mask_r <= pwdata_i[NEV-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: new faults set, write one clears, set wins
  assign ev = {bo_rise, fset & ~flag_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_r <= ev | (irq_stat_r &
                    ~((wr && paddr_i == ADDR_IRQ_STAT) ? pwdata_i[NEV-1:0] : '0));
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  card_latch_a: assert property (!card_s |=> flag_r[F_CARD] ##1 program_card_absent_indicator_o)
    else $error("card absence not latched");
  // a brown-out may legally wipe the only latched cause (watchdog, unlatched)
  fault_hold_a: assert property (fault_r && (|flag_r) && !rst_cmd |=> fault_r)
    else $error("fault mode dropped without reset");
  cable_flash_a: assert property (!cable_s |=> flag_r[F_CABLE] ##1 flash_cmd_o)
    else $error("cable removal did not command flash");
  inhibit_mon_a: assert property (inh1_act || inh2_act |-> !mon_en && !(|rf_hit))
    else $error("red-fail monitoring during inhibit");
  orc_sense_a: assert property (mon_en |-> orc_s == pol_s)
    else $error("monitoring with relay common active");
  wd_latch_a: assert property (wdl_s && flag_r[F_WDT] && !rst_cmd |=> flag_r[F_WDT])
    else $error("latched watchdog fault lost");
  wd_clear_a: assert property (!wdl_s && bo_rise && !wd_to && !rst_cmd |=> !flag_r[F_WDT])
    else $error("watchdog fault kept after power event");
  capt_hold_a: assert property (fault_r && !rst_cmd && !(|rf_hit) |=> $stable(ch_capt_r))
    else $error("captured channels changed in fault");
  status_freeze_a: assert property (fault_r ##1 fault_r |-> $stable(ch_grn_o))
    else $error("channel status moved in fault mode");
  inh_short_a: assert property ($rose(inh1_s) |-> !inh1_act [*8])
    else $error("inhibit qualified too early");

endmodule : tcmf_monitor
`default_nettype wire

// *** tb/tcmf_cabinet.sv ***
/*
  tcmf_cabinet: behavioural cabinet and controller feeding the monitor.
  assumes one clock; the bench picks the dark channels and watchdog activity.
*/
`timescale 1ns/1ps
`default_nettype none
module tcmf_cabinet
  import tcmf_pkg::*;
(
  // clock and controls
  input wire logic clk_i,
  input wire logic wd_run_i,
  input wire logic [tcmf_pkg::NCH-1:0] dark_i,
  // field signals
  output logic [tcmf_pkg::NCH-1:0] red_o,
  output logic [tcmf_pkg::NCH-1:0] yel_o,
  output logic [tcmf_pkg::NCH-1:0] grn_o,
  output logic red_enable_o,
  output logic wdog_o
);
  logic [1:0] div_r = 2'h0;
  logic wdog_r = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // every channel rests in red; a dark channel shows nothing at all
  assign red_o = ~dark_i;
  assign yel_o = '0;
  assign grn_o = '0;
  assign red_enable_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // fast toggle every 4 clocks, so the moment it stops is known to within one bench tick
  always_ff @(posedge clk_i) begin
    if (wd_run_i) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        wdog_r <= ~wdog_r;
      end
    end
  end
  assign wdog_o = wdog_r;
endmodule : tcmf_cabinet
`default_nettype wire

// *** tb/tcmf_monitor_tb.sv ***
/*
  tcmf_monitor_tb: self-checking bench for the fault supervision block.
  assumes tcmf_cabinet as far side and a 4 clock tick to keep runs short.
*/
`timescale 1ns/1ps
`default_nettype none
module tcmf_monitor_tb
  import tcmf_pkg::*;
;
  localparam int TK = 4;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd, rd;
  logic prdy, perr, irq, er, rden, wdog;
  logic [NCH-1:0] red, yel, grn, c_red, c_yel, c_grn;
  logic [NCH-1:0] dark = '0;
  logic wd_run = 1;
  logic inh1 = 0;
  logic inh2 = 0;
  logic orc = 0;
  logic pol = 0;
  logic card = 1;
  logic cable = 1;
  logic frst = 0;
  logic rrst = 0;
  logic rfsel = 0;
  logic wdsel = 0;
  logic low = 0;
  logic bosel = 0;
  logic wdl = 0;
  logic dcf = 0;
  logic conf = 0;
  logic pwr_led, wdf, rfl, pca, dgf, flash, dcl, cfl, dil, cll;
  int n_fail = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  tcmf_cabinet cab (.clk_i(clk), .wd_run_i(wd_run), .dark_i(dark), .red_o(red), .yel_o(yel),
    .grn_o(grn), .red_enable_o(rden), .wdog_o(wdog));

  // tick shortened so the millisecond timings fit the run
  tcmf_monitor #(.TICK_CYC(TK)) uut (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .irq_o(irq), .red_i(red), .yel_i(yel), .grn_i(grn), .red_enable_i(rden), .red_inhibit1_i(inh1),
    .red_inhibit2_i(inh2), .output_relay_common_sense_i(orc), .program_card_present_i(card),
    .red_interface_cable_i(cable), .watchdog_i(wdog), .low_line_i(low), .dc_fail_i(dcf),
    .conflict_i(conf), .front_reset_i(frst), .remote_reset_i(rrst), .orc_polarity_jmp_i(pol),
    .rf_time_sel_i(rfsel), .wd_time_sel_i(wdsel), .brownout_sel_i(bosel), .wd_latch_sel_i(wdl),
    .power_led_o(pwr_led), .dc_supply_fail_indicator_o(dcl), .watchdog_timeout_fault_o(wdf),
    .conflict_led_o(cfl), .red_fail_led_o(rfl), .dual_ind_led_o(dil), .clearance_led_o(cll),
    .program_card_absent_indicator_o(pca), .diag_fail_led_o(dgf), .flash_cmd_o(flash),
    .ch_red_o(c_red), .ch_yel_o(c_yel), .ch_grn_o(c_grn));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic ms(input int n);
    cyc(n * TK);
  endtask : ms

  // request held until pready is sampled high; only the hang guard ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    apb(0, ADDR_RF_EN, 0);
    chk("rf_en reset", rd, 32'(RF_EN_RST));
    apb(0, ADDR_IRQ_MASK, 0);
    chk("irq_mask reset", rd, 32'(IRQ_MASK_RST));
    apb(0, 8'h3C, 0);
    chk("unmapped err", 32'(er), 32'h0000_0001);
    apb(0, ADDR_FAULT, 0);
    chk("fault idle", rd, 32'h0000_0000);
    chk("power led", pwr_led, 1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_card();
    card <= 0;
    cyc(8);
    chk("card led", pca, 1);
    chk("card flash", flash, 1);
    dark <= 18'h0_0020;
    frst <= 1;
    cyc(1);
    frst <= 0;
    cyc(6);
    chk("status frozen", c_red[5], 1);
    chk("card held", pca, 1);
    dark <= '0;
    card <= 1;
    cyc(6);
    frst <= 1;
    cyc(1);
    frst <= 0;
    cyc(4);
    chk("card cleared", pca, 0);
    chk("card flash off", flash, 0);
    apb(0, ADDR_IRQ_STAT, 0);
    chk("card event", rd[F_CARD], 1);
    chk("irq masked", irq, 0);
    $display("test card done");
  endtask : t_card

  task automatic t_rf(input logic sel, input int ch);
    int lim;
    lim = sel ? int'(RF_ON_MS) : int'(RF_OFF_MS);
    apb(1, ADDR_IRQ_MASK, 32'h0000_0002);
    rfsel <= sel;
    dark <= NCH'(1) << ch;
    ms(lim - 3);
    chk("rf early", rfl, 0);
    ms(6);
    chk("rf led", rfl, 1);
    chk("rf flash", flash, 1);
    chk("rf irq", irq, 1);
    apb(0, ADDR_CH_CAPT, 0);
    chk("rf capture", rd, 32'(NCH'(1) << ch));
    dark <= '0;
    cyc(6);
    chk("rf held", rfl, 1);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    apb(1, ADDR_IRQ_STAT, 32'h0000_003F);
    cyc(4);
    chk("rf cleared", rfl, 0);
    chk("irq cleared", irq, 0);
    $display("test red fail %0d done", sel);
  endtask : t_rf

  // k: inhibit 1, inhibit 2, relay common, short inhibit pulse, inverted relay common
  task automatic t_sup(input int k);
    // short limit, so an unsuppressed channel trips inside the window
    rfsel <= 0;
    inh1 <= (k == 0 || k == 3);
    inh2 <= (k == 1);
    orc <= (k == 2);
    pol <= (k == 4);
    if (k == 3) begin
      ms(200);
      inh1 <= 0;
      ms(400);
    end else begin
      ms(k < 2 ? 600 : 10);
    end
    dark <= 18'h0_0002;
    ms(900);
    chk("rf suppress", rfl, k == 3);
    inh1 <= 0;
    inh2 <= 0;
    orc <= 0;
    pol <= 0;
    dark <= '0;
    cyc(6);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    cyc(4);
    $display("test suppress %0d done", k);
  endtask : t_sup

  task automatic t_wdt();
    wdsel <= 1;
    wd_run <= 0;
    ms(int'(WD_ON_MS) - 3);
    chk("wdt early", wdf, 0);
    ms(6);
    chk("wdt led", wdf, 1);
    chk("wdt flash", flash, 1);
    wd_run <= 1;
    cyc(8);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    cyc(4);
    chk("wdt cleared", wdf, 0);
    $display("test watchdog done");
  endtask : t_wdt

  // watchdog fault first, then a brown-out onset; the latch decides if it survives
  task automatic t_bo(input logic latch);
    wdl <= latch;
    bosel <= 1;
    wd_run <= 0;
    ms(int'(WD_ON_MS) + 3);
    chk("bo wdt set", wdf, 1);
    low <= 1;
    ms(int'(BO_ON_MS) - 3);
    chk("bo early", pwr_led, 1);
    ms(6);
    chk("bo power led", pwr_led, 0);
    chk("bo flash", flash, 1);
    chk("bo wdt kept", wdf, latch);
    low <= 0;
    wd_run <= 1;
    cyc(8);
    chk("bo restored", pwr_led, 1);
    chk("bo wdt after", wdf, latch);
    chk("bo flash after", flash, latch);
    apb(0, ADDR_IRQ_STAT, 0);
    chk("bo event", rd[NEV-1], 1);
    apb(1, ADDR_IRQ_STAT, 32'h0000_0020);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    cyc(4);
    chk("bo wdt cleared", wdf, 0);
    wdl <= 0;
    $display("test brown-out %0d done", latch);
  endtask : t_bo

  // conflict keeps the lit channels; dc failure is a live lamp
  task automatic t_conf();
    dark <= 18'h0_00F0;
    conf <= 1;
    dcf <= 1;
    cyc(8);
    chk("conflict led", cfl, 1);
    chk("dc fail led", dcl, 1);
    chk("conflict flash", flash, 1);
    conf <= 0;
    dark <= '0;
    dcf <= 0;
    cyc(8);
    apb(0, ADDR_CH_CAPT, 0);
    chk("conflict capture", rd, 32'h0003_FF0F);
    chk("conflict status", 32'(c_red), 32'h0003_FF0F);
    chk("conflict held", cfl, 1);
    chk("dc fail clear", dcl, 0);
    chk("unused lamps", 32'({dil, cll}), 0);
    chk("status yel grn", 32'(c_yel | c_grn), 0);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    cyc(4);
    chk("conflict cleared", cfl, 0);
    $display("test conflict done");
  endtask : t_conf

  task automatic t_cable();
    cable <= 0;
    cyc(8);
    chk("cable led", dgf, 1);
    chk("cable flash", flash, 1);
    rrst <= 1;
    cyc(1);
    rrst <= 0;
    cyc(4);
    chk("cable held", dgf, 1);
    cable <= 1;
    cyc(6);
    rrst <= 1;
    cyc(1);
    rrst <= 0;
    cyc(4);
    chk("cable cleared", dgf, 0);
    $display("test cable done");
  endtask : t_cable

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  initial begin
    cyc(16);
    rst <= 0;
    // card and cable flags latch at start-up, so clear them first
    cyc(6);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    cyc(4);
    t_regs();
    t_card();
    t_rf(0, 0);
    t_rf(1, 17);
    for (int k = 0; k < 5; k++) begin
      t_sup(k);
    end
    t_wdt();
    t_bo(0);
    t_bo(1);
    t_cable();
    t_conf();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("[FAIL] run time expected end seen hang");
    close_out();
  end
endmodule : tcmf_monitor_tb
`default_nettype wire
